// ===== bench/dacstc_top_properties.sv
// Port checks of the converter trigger block.
`timescale 1ns/100ps
`default_nettype none
module dacstc_chk #(
   parameter int WIDTH = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Bus
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   // Outputs
   input wire logic [WIDTH-1:0] chan1_output_reg_o,
   input wire logic [WIDTH-1:0] chan2_output_reg_o
);
   logic wr_r, rd_r;
   logic [11:0] ofs_r;
   logic [WIDTH-1:0] h1_r, h2_r;
   logic [1:0] md_r;
   wire logic k1 = wr_r && ofs_r == 12'h004 && hwdata_i[0];
   wire logic k2 = wr_r && ofs_r == 12'h004 && hwdata_i[1];
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         ofs_r <= 12'h000;
      end else if (hready_i) begin
         wr_r <= hsel_i && htrans_i[1] && hwrite_i;
         rd_r <= hsel_i && htrans_i[1] && !hwrite_i;
         ofs_r <= haddr_i[11:0];
      end
   end
   // Shadows of what software wrote to the holding and mode registers.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         h1_r <= {WIDTH{1'b0}};
         h2_r <= {WIDTH{1'b0}};
         md_r <= 2'h3;
      end else if (wr_r && hready_i) begin
         if (ofs_r == 12'h008)
            h1_r <= hwdata_i[WIDTH-1:0];
         if (ofs_r == 12'h00C)
            h1_r <= hwdata_i[WIDTH+3:4];
         if (ofs_r == 12'h010)
            h2_r <= hwdata_i[WIDTH-1:0];
         if (ofs_r == 12'h014)
            md_r <= hwdata_i[1:0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_go1;
      k1 && md_r[0];
   endsequence
   AST_COPY1: assert property (s_go1 |-> ##2 chan1_output_reg_o == $past(h1_r, 2))
      else $error("ch1 copy wrong");
   AST_COPY2: assert property (k2 && md_r[1] |-> ##2 chan2_output_reg_o == $past(h2_r, 2))
      else $error("ch2 copy wrong");
   AST_SKIP1: assert property (k1 && !md_r[0] |-> ##2 $stable(chan1_output_reg_o))
      else $error("ch1 copied in other mode");
   AST_CAUSE1: assert property ($changed(chan1_output_reg_o) |-> $past(k1 && md_r[0], 2))
      else $error("ch1 changed untriggered");
   AST_SKIP2: assert property (k2 && !md_r[1] |-> ##2 $stable(chan2_output_reg_o))
      else $error("ch2 copied in other mode");
   AST_CAUSE2: assert property ($changed(chan2_output_reg_o) |-> $past(k2 && md_r[1], 2))
      else $error("ch2 changed untriggered");
   AST_READ1: assert property (rd_r && ofs_r == 12'h008 |->
      hrdata_o == {{(32-WIDTH){1'b0}}, h1_r})
      else $error("hold read wrong");
endmodule // dacstc_chk
bind dacstc_top dacstc_chk #(.WIDTH(WIDTH)) i_dacstc_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .chan1_output_reg_o(chan1_output_reg_o), .chan2_output_reg_o(chan2_output_reg_o));
`default_nettype wire

// ===== bench/dacstc_top_test.sv
// Self-checking testbench of the converter trigger block.
`timescale 1ns/100ps
`default_nettype none
module dacstc_top_test;
   logic clk_i = 1'b0, arst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic [1:0] htrans_i = 2'h0;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
   logic hreadyout_o, hresp_o;
   logic [11:0] ch1, ch2;
   int bad_count = 0, samples_checked = 0, cyc = 0;
   always #50 clk_i = ~clk_i;
   dacstc_top i_dacstc_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .chan1_output_reg_o(ch1),
      .chan2_output_reg_o(ch2));
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= w;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rd, exp);
      check({31'h0, hresp_o}, 32'h0);
   endtask
   task automatic trig(input logic [1:0] m, input logic [11:0] e1, input logic [11:0] e2);
      xfer(1'b1, 32'h4, {30'h0, m});
      repeat (2) @(posedge clk_i);
      check({20'h0, ch1}, {20'h0, e1});
      check({20'h0, ch2}, {20'h0, e2});
   endtask
   task automatic test_hold;
      rdchk(32'h14, 32'h3);
      rdchk(32'h8, 32'h0);
      xfer(1'b1, 32'h8, 32'hFFFFFFFF);
      rdchk(32'h8, 32'hFFF);
      xfer(1'b1, 32'hC, 32'h0000ABC0);
      rdchk(32'h8, 32'hABC);
      rdchk(32'hC, 32'hABC0);
      xfer(1'b1, 32'h100, 32'hFFFFFFFF);
      rdchk(32'h100, 32'h0);
   endtask
   task automatic test_trig;
      xfer(1'b1, 32'h8, 32'hABC);
      trig(2'h1, 12'hABC, 12'h000);
      xfer(1'b1, 32'h10, 32'h123);
      trig(2'h2, 12'hABC, 12'h123);
      rdchk(32'h1C, 32'h123);
      xfer(1'b1, 32'h8, 32'h0FE);
      trig(2'h3, 12'h0FE, 12'h123);
   endtask
   task automatic test_mode;
      xfer(1'b1, 32'h14, 32'h0);
      xfer(1'b1, 32'h8, 32'h555);
      xfer(1'b1, 32'h10, 32'h666);
      trig(2'h3, 12'h0FE, 12'h123);
      xfer(1'b1, 32'h14, 32'h3);
      trig(2'h3, 12'h555, 12'h666);
   endtask
   task automatic test_kick;
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= 32'h8;
      hwrite_i <= 1'b1;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hwdata_i <= 32'h789;
      hwrite_i <= 1'b0;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      check(hrdata_o, 32'h789);
      xfer(1'b1, 32'h4, 32'h1);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= 1'b0;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      check(hrdata_o, 32'h1);
      rdchk(32'h4, 32'h0);
      rdchk(32'h18, 32'h789);
   endtask
   task automatic finish_test;
      $display("checked %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         finish_test;
      end
   end
   initial begin
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      test_hold;
      test_trig;
      test_mode;
      test_kick;
      finish_test;
   end
endmodule // dacstc_top_test
`default_nettype wire

// ===== logic/dacstc_chan.sv
// One converter channel: software kick, hold-to-output copy and kick clearing.
`timescale 1ns/100ps
`default_nettype none
`include "dacstc_consts.svh"

module dacstc_chan #(
   parameter int WIDTH = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Control
   input wire logic soft_mode_i,
   input wire logic kick_set_i,
   input wire logic [WIDTH-1:0] hold_i,
   // State
   output logic kick_o,
   output logic [WIDTH-1:0] out_o
);
   if (WIDTH < 1) begin : g_width_check
      $error("dacstc_chan: WIDTH must be positive");
   end

   dacstc_pkg::dacstc_kick_type state_r;

   // Kick bit: set by software, cleared one cycle after the copy.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= dacstc_pkg::DACSTC_IDLE;
         kick_o <= 1'b0;
      end else begin
         case (state_r)
            dacstc_pkg::DACSTC_IDLE: begin
               if (kick_set_i && soft_mode_i) begin
                  kick_o <= 1'b1;
                  state_r <= dacstc_pkg::DACSTC_LOADED;
               end
            end
            dacstc_pkg::DACSTC_LOADED: begin
               kick_o <= 1'b0;
               state_r <= dacstc_pkg::DACSTC_IDLE;
            end
            default: state_r <= dacstc_pkg::DACSTC_IDLE;
         endcase
      end
   end

   // Output register takes the held sample on the edge that sets the kick.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_o <= '0;
      end else if (state_r == dacstc_pkg::DACSTC_IDLE && kick_set_i && soft_mode_i) begin
         out_o <= hold_i;
      end
   end
endmodule // dacstc_chan

`default_nettype wire

// ===== logic/dacstc_top.sv
// Software trigger and holding registers of a two-channel converter, AHB-Lite slave.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "dacstc_consts.svh"

module dacstc_top #(
   parameter int WIDTH = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Converter outputs
   output logic [WIDTH-1:0] chan1_output_reg_o,
   output logic [WIDTH-1:0] chan2_output_reg_o
);
   // ----------------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------------
   // The register layout places a 12-bit sample, so no other width can be served.
   if (WIDTH != 12) begin : g_width_check
      $error("dacstc_top: only 12-bit samples are served");
   end

   // ----------------------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------------------
   logic wr_pend_r;
   logic [11:0] addr_r;
   logic [WIDTH-1:0] chan1_holding_reg_r;
   logic [WIDTH-1:0] chan2_holding_reg_r;
   logic [1:0] soft_mode_r;
   logic take;

   assign take = hsel_i && hready_i && htrans_i[1];

   // A write is remembered for its data phase; reads are answered from the address phase.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_pend_r <= 1'b0;
      end else if (hready_i) begin
         wr_pend_r <= take && hwrite_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         addr_r <= 12'h000;
      end else if (hready_i) begin
         addr_r <= haddr_i[11:0];
      end
   end

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------------------------------------------
   // Software-written registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chan1_holding_reg_r <= `DACSTC_SAMPLE_RST;
      end else if (wr_pend_r && hit(addr_r, `DACSTC_CH1_RHOLD_OFS)) begin
         chan1_holding_reg_r <= hwdata_i[`DACSTC_SAMPLE_MSB:0];
      end else if (wr_pend_r && hit(addr_r, `DACSTC_CH1_LHOLD_OFS)) begin
         chan1_holding_reg_r <= hwdata_i[`DACSTC_LALIGN_MSB:`DACSTC_LALIGN_LSB];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chan2_holding_reg_r <= `DACSTC_SAMPLE_RST;
      end else if (wr_pend_r && hit(addr_r, `DACSTC_CH2_RHOLD_OFS)) begin
         chan2_holding_reg_r <= hwdata_i[`DACSTC_SAMPLE_MSB:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         soft_mode_r <= `DACSTC_MODE_RST;
      end else if (wr_pend_r && hit(addr_r, `DACSTC_MODE_OFS)) begin
         soft_mode_r <= hwdata_i[1:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------------------
   logic trig_wr;
   logic [1:0] kick_set;
   logic [1:0] kick;
   logic [1:0][WIDTH-1:0] hold;
   logic [1:0][WIDTH-1:0] out;

   assign trig_wr = wr_pend_r && hit(addr_r, `DACSTC_SOFT_TRIG_OFS);
   assign hold[0] = chan1_holding_reg_r;
   assign hold[1] = chan2_holding_reg_r;

   // Bits 31:2 of a trigger write are ignored; software keeps them zero.
   assign kick_set[0] = trig_wr && hwdata_i[`DACSTC_KICK1_BIT];
   assign kick_set[1] = trig_wr && hwdata_i[`DACSTC_KICK2_BIT];

   // A kick is honoured only while its channel is idle, so a kick bit that is
   // still set swallows a second trigger instead of copying twice.
   for (genvar c = 0; c < 2; c++) begin : g_chan
      dacstc_chan #(
         .WIDTH(WIDTH)
      ) i_dacstc_chan (
         .clk_i(clk_i),
         .arst_n_i(arst_n_i),
         .soft_mode_i(soft_mode_r[c]),
         .kick_set_i(kick_set[c]),
         .hold_i(hold[c]),
         .kick_o(kick[c]),
         .out_o(out[c])
      );
   end

   // The output pins follow the channel output registers one edge later.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chan1_output_reg_o <= '0;
      end else begin
         chan1_output_reg_o <= out[0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chan2_output_reg_o <= '0;
      end else begin
         chan2_output_reg_o <= out[1];
      end
   end

   // ----------------------------------------------------------------------------
   // Read data and response
   // ----------------------------------------------------------------------------
   logic [WIDTH-1:0] hold1_view;
   logic [WIDTH-1:0] hold2_view;
   logic [1:0] mode_view;
   logic [31:0] rd_nxt;

   // A read of a holding or mode register taken on the edge at which a write lands sees the newly written value.
   always_comb begin
      hold1_view = chan1_holding_reg_r;
      hold2_view = chan2_holding_reg_r;
      mode_view = soft_mode_r;
      if (wr_pend_r) begin
         case (addr_r)
            `DACSTC_CH1_RHOLD_OFS: hold1_view = hwdata_i[`DACSTC_SAMPLE_MSB:0];
            `DACSTC_CH1_LHOLD_OFS: hold1_view = hwdata_i[`DACSTC_LALIGN_MSB:`DACSTC_LALIGN_LSB];
            `DACSTC_CH2_RHOLD_OFS: hold2_view = hwdata_i[`DACSTC_SAMPLE_MSB:0];
            `DACSTC_MODE_OFS: mode_view = hwdata_i[1:0];
            default: mode_view = soft_mode_r;
         endcase
      end
   end

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (haddr_i[11:0])
         `DACSTC_SOFT_TRIG_OFS: rd_nxt = {30'h0000_0000, kick};
         `DACSTC_CH1_RHOLD_OFS: rd_nxt = {20'h0_0000, hold1_view};
         `DACSTC_CH1_LHOLD_OFS: rd_nxt = {16'h0000, hold1_view, 4'h0};
         `DACSTC_CH2_RHOLD_OFS: rd_nxt = {20'h0_0000, hold2_view};
         `DACSTC_MODE_OFS: rd_nxt = {30'h0000_0000, mode_view};
         `DACSTC_CH1_OUT_OFS: rd_nxt = {20'h0_0000, out[0]};
         `DACSTC_CH2_OUT_OFS: rd_nxt = {20'h0_0000, out[1]};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (take && !hwrite_i) begin
         hrdata_o <= rd_nxt;
      end
   end

   // Zero wait states and an OKAY answer to every transfer.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end
endmodule // dacstc_top

`default_nettype wire

// ===== shared/dacstc_consts.svh
// Offsets, field positions, reset values and timing counts of the converter trigger block.
`ifndef DACSTC_CONSTS_SVH
`define DACSTC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DACSTC_SOFT_TRIG_OFS 12'h004
`define DACSTC_CH1_RHOLD_OFS 12'h008
`define DACSTC_CH1_LHOLD_OFS 12'h00C
`define DACSTC_CH2_RHOLD_OFS 12'h010
`define DACSTC_MODE_OFS 12'h014
`define DACSTC_CH1_OUT_OFS 12'h018
`define DACSTC_CH2_OUT_OFS 12'h01C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define DACSTC_KICK1_BIT 0
`define DACSTC_KICK2_BIT 1
`define DACSTC_SAMPLE_MSB 11
`define DACSTC_LALIGN_LSB 4
`define DACSTC_LALIGN_MSB 15
`define DACSTC_SAMPLE_RST 12'h000
`define DACSTC_MODE_RST 2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DACSTC_CLEAR_DELAY_CYC 1

`endif

// ===== shared/dacstc_pkg.sv
// Types shared by the converter trigger block.
package dacstc_pkg;
   typedef enum logic [1:0] {
      DACSTC_IDLE,
      DACSTC_LOADED
   } dacstc_kick_type;
   typedef logic [11:0] dacstc_sample_type;
endpackage : dacstc_pkg
